/* File: hdl/local_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module local_reg_bank (
  input  wire logic        i_core_clk,
  input  wire logic        i_wr_a_en,
  input  wire logic [5:0]  i_wr_a_addr,
  input  wire logic [31:0] i_wr_a_data,
  input  wire logic        i_wr_b_en,
  input  wire logic [5:0]  i_wr_b_addr,
  input  wire logic [31:0] i_wr_b_data,
  input  wire logic [5:0]  i_rd_a_addr,
  output logic [31:0]      o_rd_a_data,
  input  wire logic [5:0]  i_rd_b_addr,
  output logic [31:0]      o_rd_b_data
);
  // Data only, no reset: software never reads a slot before writing it
  logic [31:0] store [stack_frame_pkg::NUM_LOCAL];

  assign o_rd_a_data = store[i_rd_a_addr];
  assign o_rd_b_data = store[i_rd_b_addr];

  always_ff @(posedge i_core_clk) begin
    if (i_wr_a_en) begin
      store[i_wr_a_addr] <= i_wr_a_data;
    end
    if (i_wr_b_en) begin
      store[i_wr_b_addr] <= i_wr_b_data;
    end
  end
endmodule : local_reg_bank
`default_nettype wire

/* File: hdl/mem_spill_port.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_spill_port (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  spill_if.port            spill,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata
);
  logic        busy_reg;
  logic        we_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic        start;

  assign start       = spill.req & ~busy_reg;
  assign spill.done  = busy_reg & i_mem_ack;
  assign spill.rdata = i_mem_rdata;
  assign o_mem_req   = busy_reg;
  assign o_mem_we    = we_reg;
  assign o_mem_addr  = addr_reg;
  assign o_mem_wdata = wdata_reg;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg  <= 1'b0;
      we_reg    <= 1'b0;
      addr_reg  <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
    end else begin
      busy_reg <= start | (busy_reg & ~i_mem_ack);
      if (start) begin
        we_reg    <= spill.we;
        addr_reg  <= spill.addr;
        wdata_reg <= spill.wdata;
      end
    end
  end
endmodule : mem_spill_port
`default_nettype wire

/* File: hdl/register_stack_frame_manager.sv */
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Register part of the stack is 64 local registers in one circular buffer.
// - Current frame always stays wholly resident in the local registers.
// - Frame base marks frame register zero; size field counts up to 16.
// - Stack grows upward; memory part is checked against the upper limit.
// - Invoke, trap and software op advance base and set size to six.
// - Invoke advances base by destination code; destination becomes register zero.
// - Exception advances base by current size, then sets size to two.
// - Reshape lowers base by second operand, loads size from first operand.
// - Reshape guarantees ten free local registers beyond the new frame.
// - Shortfall against size plus ten is pushed to the memory stack.
// - After that push, trap when the old stack top exceeded the limit.
// - Release restores preceding frame, pulling any missing part from memory.
// - At size sixteen, destination code zero means the register past fifteen.
// - Supervisor frames stack onto the same stack as user frames.
// - Physical index is base plus register code, modulo 64.
module register_stack_frame_manager (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_op_valid,
  input  wire logic [2:0]  i_op_kind,
  input  wire logic [3:0]  i_op_a,
  input  wire logic [3:0]  i_op_b,
  input  wire logic [5:0]  i_prev_fp,
  input  wire logic [3:0]  i_prev_fl,
  input  wire logic [31:0] i_ret_pc,
  input  wire logic [31:0] i_ret_sr,
  output logic             o_op_ready,
  input  wire logic [3:0]  i_rd_code,
  output logic [31:0]      o_rd_data,
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_wr_code,
  input  wire logic [31:0] i_wr_data,
  output logic [5:0]       o_frame_base_pointer,
  output logic [3:0]       o_frame_size_field,
  output logic             o_frame_error,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata
);
  stack_frame_pkg::mgr_state_t state_reg;
  stack_frame_pkg::mgr_state_t state_next;

  logic [5:0]        fp_reg;
  logic [5:0]        fp_next;
  logic [3:0]        fl_reg;
  logic [3:0]        fl_next;
  logic signed [7:0] depth_reg;
  logic signed [7:0] depth_next;
  logic [31:0]       sp_reg;
  logic [31:0]       sp_next;
  logic [31:0]       limit_reg;
  logic [31:0]       old_sp_reg;
  logic [6:0]        count_reg;
  logic [6:0]        count_next;
  logic              wait_reg;
  logic              err_reg;
  logic              err_next;
  logic [31:0]       rd_data_reg;
  logic [31:0]       reg_rdata_reg;
  logic [31:0]       reg_rdata_next;

  spill_if spill_bus ();

  // Operation decode
  logic idle;
  logic accept;
  logic is_call;
  logic is_exc;
  logic is_save;
  logic is_frame;
  logic is_rel;
  assign idle     = (state_reg == stack_frame_pkg::ST_IDLE);
  assign accept   = i_op_valid & idle;
  // User and supervisor frames share one stack, no privilege split
  assign is_call  = accept & ((i_op_kind == stack_frame_pkg::OP_CALL) |
                              (i_op_kind == stack_frame_pkg::OP_TRAP) |
                              (i_op_kind == stack_frame_pkg::OP_SOFT));
  assign is_exc   = accept & (i_op_kind == stack_frame_pkg::OP_EXC);
  assign is_save  = is_call | is_exc;
  assign is_frame = accept & (i_op_kind == stack_frame_pkg::OP_FRAME);
  assign is_rel   = accept & (i_op_kind == stack_frame_pkg::OP_RELEASE);

  // Effective sizes, zero field standing for sixteen
  logic [4:0] fl_eff;
  logic [4:0] dest_eff;
  logic [4:0] prev_eff;
  logic [4:0] shift_up;
  assign fl_eff   = (fl_reg == 4'h0) ? stack_frame_pkg::FL_MAX : {1'b0, fl_reg};
  assign dest_eff = (i_op_a == 4'h0 && fl_reg == 4'h0) ? stack_frame_pkg::FL_MAX
                                                         : {1'b0, i_op_a};
  assign prev_eff = (i_prev_fl == 4'h0) ? stack_frame_pkg::FL_MAX : {1'b0, i_prev_fl};
  assign shift_up = is_exc ? fl_eff : dest_eff;

  // New frame base and size
  logic [5:0] call_fp;
  logic [5:0] frame_fp;
  logic [5:0] top_now;
  logic [5:0] top_prev;
  logic [5:0] rel_drop;
  logic [5:0] bottom;
  assign call_fp  = fp_reg + {1'b0, shift_up};
  assign frame_fp = fp_reg - {2'b00, i_op_b};
  assign top_now  = fp_reg + {1'b0, fl_eff};
  assign top_prev = i_prev_fp + {1'b0, prev_eff};
  assign rel_drop = top_now - top_prev;
  // Oldest resident register; negative depth wraps above the top on purpose
  assign bottom   = top_now - depth_reg[5:0];

  assign fp_next = is_save  ? call_fp  :
                   is_frame ? frame_fp :
                   is_rel   ? i_prev_fp : fp_reg;
  assign fl_next = is_call  ? stack_frame_pkg::FL_CALL :
                   is_exc   ? stack_frame_pkg::FL_EXC  :
                   is_frame ? i_op_a                   :
                   is_rel   ? i_prev_fl : fl_reg;

  // Resident-depth bookkeeping
  logic [4:0]        nfl_eff;
  logic signed [7:0] nfl_s;
  logic signed [7:0] fl_s;
  logic signed [7:0] shift_s;
  logic signed [7:0] delta;
  logic signed [7:0] depth_op;
  logic signed [7:0] shortfall;
  logic signed [7:0] missing;
  assign nfl_eff   = (fl_next == 4'h0) ? stack_frame_pkg::FL_MAX : {1'b0, fl_next};
  assign nfl_s     = $signed({3'b000, nfl_eff});
  assign fl_s      = $signed({3'b000, fl_eff});
  assign shift_s   = is_save  ? $signed({3'b000, shift_up}) :
                     is_frame ? -$signed({4'h0, i_op_b}) : 8'sh00;
  assign delta     = is_rel ? -$signed({2'b00, rel_drop}) : (shift_s + nfl_s - fl_s);
  assign depth_op  = depth_reg + delta;
  assign shortfall = depth_op + stack_frame_pkg::RESERVE - stack_frame_pkg::DEPTH_CAP;
  assign missing   = $signed({3'b000, prev_eff}) - depth_op;

  logic go_push;
  logic go_pull;
  logic in_push;
  logic step_done;
  logic last_step;
  assign go_push   = is_frame & (shortfall > 8'sh00);
  assign go_pull   = is_rel & (missing > 8'sh00);
  assign in_push   = (state_reg == stack_frame_pkg::ST_PUSH);
  assign step_done = spill_bus.done;
  assign last_step = step_done & (count_reg == 7'h01);

  // Spill and refill steps, one word per memory handshake
  assign spill_bus.req   = ~idle & ~wait_reg;
  assign spill_bus.we    = in_push;
  assign spill_bus.addr  = in_push ? sp_reg : (sp_reg - stack_frame_pkg::WORD_BYTES);
  logic [31:0] bank_rd_a;
  logic [31:0] bank_rd_b;
  assign spill_bus.wdata = bank_rd_b;

  assign depth_next = accept    ? depth_op :
                      step_done ? (in_push ? depth_reg - 8'sh01 : depth_reg + 8'sh01) :
                      depth_reg;
  assign sp_next    = (step_done & in_push)  ? sp_reg + stack_frame_pkg::WORD_BYTES :
                      (step_done & ~in_push) ? sp_reg - stack_frame_pkg::WORD_BYTES :
                      (idle & i_reg_wr & (i_reg_addr == stack_frame_pkg::ADDR_STACK_TOP)) ?
                      i_reg_wdata : sp_reg;
  assign count_next = go_push   ? 7'(shortfall) :
                      go_pull   ? 7'(missing)   :
                      step_done ? count_reg - 7'h01 : count_reg;
  assign state_next = go_push   ? stack_frame_pkg::ST_PUSH :
                      go_pull   ? stack_frame_pkg::ST_PULL :
                      last_step ? stack_frame_pkg::ST_IDLE : state_reg;
  // Compare uses the top before the push, not after
  assign err_next   = last_step & in_push & (old_sp_reg > limit_reg);

  // Bank ports: A serves the core, refills and saved counter; B the saved status and the spill reads
  logic       pull_wr;
  logic       wr_a_en;
  logic [5:0] wr_a_addr;
  logic [31:0] wr_a_data;
  logic [5:0] rd_abs;
  assign pull_wr   = step_done & ~in_push;
  assign wr_a_en   = pull_wr | is_save | (idle & i_wr_en);
  assign wr_a_addr = pull_wr ? bottom - 6'h01 :
                     is_save ? call_fp : fp_reg + {2'b00, i_wr_code};
  assign wr_a_data = pull_wr ? spill_bus.rdata : is_save ? i_ret_pc : i_wr_data;
  assign rd_abs    = fp_reg + {2'b00, i_rd_code};

  local_reg_bank u_bank (
    .i_core_clk  (i_core_clk),
    .i_wr_a_en   (wr_a_en),
    .i_wr_a_addr (wr_a_addr),
    .i_wr_a_data (wr_a_data),
    .i_wr_b_en   (is_save),
    .i_wr_b_addr (call_fp + 6'h01),
    .i_wr_b_data (i_ret_sr),
    .i_rd_a_addr (rd_abs),
    .o_rd_a_data (bank_rd_a),
    .i_rd_b_addr (bottom),
    .o_rd_b_data (bank_rd_b)
  );

  mem_spill_port u_port (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .spill       (spill_bus.port),
    .o_mem_req   (o_mem_req),
    .o_mem_we    (o_mem_we),
    .o_mem_addr  (o_mem_addr),
    .o_mem_wdata (o_mem_wdata),
    .i_mem_ack   (i_mem_ack),
    .i_mem_rdata (i_mem_rdata)
  );

  // Register bus read mux; unmapped reads answer zero
  logic [31:0] status_word;
  // Logical not stays one bit wide; depth zero-extends so a negative count spares busy
  assign status_word = (32'(!idle) << stack_frame_pkg::ST_BUSY_BIT) |
                       (32'($unsigned(depth_reg)) << stack_frame_pkg::ST_DEPTH_LSB) |
                       (32'(fl_reg) << stack_frame_pkg::ST_FL_LSB) |
                       (32'(fp_reg) << stack_frame_pkg::ST_FP_LSB);
  assign reg_rdata_next = ~i_reg_rd ? 32'h0000_0000 :
                          (i_reg_addr == stack_frame_pkg::ADDR_STACK_TOP) ? sp_reg :
                          (i_reg_addr == stack_frame_pkg::ADDR_LIMIT) ? limit_reg :
                          (i_reg_addr == stack_frame_pkg::ADDR_STATUS) ? status_word :
                          32'h0000_0000;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= stack_frame_pkg::ST_IDLE;
      fp_reg    <= stack_frame_pkg::FP_RESET;
      fl_reg    <= stack_frame_pkg::FL_RESET;
      depth_reg <= stack_frame_pkg::DEPTH_RESET;
      sp_reg    <= stack_frame_pkg::SP_RESET;
      count_reg <= 7'h00;
      wait_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      fp_reg    <= fp_next;
      fl_reg    <= fl_next;
      depth_reg <= depth_next;
      sp_reg    <= sp_next;
      count_reg <= count_next;
      wait_reg  <= spill_bus.req | (wait_reg & ~step_done);
      err_reg   <= err_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      limit_reg     <= stack_frame_pkg::LIMIT_RESET;
      old_sp_reg    <= stack_frame_pkg::SP_RESET;
      rd_data_reg   <= 32'h0000_0000;
      reg_rdata_reg <= 32'h0000_0000;
    end else begin
      if (i_reg_wr && i_reg_addr == stack_frame_pkg::ADDR_LIMIT) begin
        limit_reg <= i_reg_wdata;
      end
      if (go_push) begin
        old_sp_reg <= sp_reg;
      end
      rd_data_reg   <= bank_rd_a;
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  assign o_op_ready           = idle;
  assign o_rd_data            = rd_data_reg;
  assign o_frame_base_pointer = fp_reg;
  assign o_frame_size_field   = fl_reg;
  assign o_frame_error        = err_reg;
  assign o_reg_rdata          = reg_rdata_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  property p_call_len;
    is_call |=> (fl_reg == stack_frame_pkg::FL_CALL) && (fl_eff == 5'h06);
  endproperty
  a_call_len: assert property (p_call_len) else $error("call size not six");

  property p_call_fp;
    (is_call && !(i_op_a == 4'h0 && fl_reg == 4'h0)) |=>
      fp_reg == 6'($past(fp_reg) + $past(i_op_a));
  endproperty
  a_call_fp: assert property (p_call_fp) else $error("call base wrong");

  property p_call16;
    (is_call && i_op_a == 4'h0 && fl_reg == 4'h0) |=> fp_reg == 6'($past(fp_reg) + 6'h10);
  endproperty
  a_call16: assert property (p_call16) else $error("code zero not past fifteen");

  property p_exc;
    is_exc |=> (fp_reg == 6'($past(fp_reg) + $past(fl_eff))) && (fl_reg == 4'h2);
  endproperty
  a_exc: assert property (p_exc) else $error("exception frame wrong");

  property p_frame;
    is_frame |=> (fp_reg == 6'($past(fp_reg) - $past(i_op_b))) && (fl_reg == $past(i_op_a));
  endproperty
  a_frame: assert property (p_frame) else $error("reshape wrong");

  property p_len16;
    (is_frame && i_op_a == 4'h0) |=> fl_eff == 5'h10;
  endproperty
  a_len16: assert property (p_len16) else $error("zero field not sixteen");

  property p_push_go;
    go_push |=> in_push && (count_reg == 7'($past(depth_op) - 7'h36));
  endproperty
  a_push_go: assert property (p_push_go) else $error("push count wrong");

  property p_reserve;
    (in_push && last_step) |=> idle && (depth_reg <= 8'sh36);
  endproperty
  a_reserve: assert property (p_reserve) else $error("reserve not kept");

  property p_push_step;
    (in_push && step_done) |=> (sp_reg == $past(sp_reg) + 32'h4) &&
                               (depth_reg == $past(depth_reg) - 8'sh01);
  endproperty
  a_push_step: assert property (p_push_step) else $error("spill step wrong");

  property p_err;
    o_frame_error |-> $past(in_push) && $past(old_sp_reg) > $past(limit_reg);
  endproperty
  a_err: assert property (p_err) else $error("bound trap unjustified");

  property p_pull;
    go_pull |=> (state_reg == stack_frame_pkg::ST_PULL) ##1 o_mem_req && !o_mem_we;
  endproperty
  a_pull: assert property (p_pull) else $error("release did not refill");

  c_push:  cover property (go_push);
  c_pull:  cover property (go_pull);
  c_error: cover property (o_frame_error);
  c_call16: cover property (is_call && i_op_a == 4'h0 && fl_reg == 4'h0);
endmodule : register_stack_frame_manager
`default_nettype wire

/* File: hdl/spill_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spill_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;
  modport mgr  (output req, output we, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : spill_if
`default_nettype wire

/* File: hdl/stack_frame_pkg.sv */
package stack_frame_pkg;
  localparam int                NUM_LOCAL    = 64;
  localparam logic [4:0]        FL_MAX       = 5'h10;
  localparam logic [3:0]        FL_CALL      = 4'h6;
  localparam logic [3:0]        FL_EXC       = 4'h2;
  localparam logic [3:0]        FL_RESET     = 4'h6;
  localparam logic signed [7:0] DEPTH_RESET  = 8'sh06;
  localparam logic signed [7:0] RESERVE      = 8'sh0A;
  localparam logic signed [7:0] DEPTH_CAP    = 8'sh40;
  localparam logic [5:0]        FP_RESET     = 6'h00;
  localparam logic [31:0]       WORD_BYTES   = 32'h0000_0004;
  localparam logic [31:0]       SP_RESET     = 32'h0000_0000;
  localparam logic [31:0]       LIMIT_RESET  = 32'hFFFF_FFFF;
  localparam logic [3:0]        ADDR_STACK_TOP = 4'h0;
  localparam logic [3:0]        ADDR_LIMIT     = 4'h4;
  localparam logic [3:0]        ADDR_STATUS    = 4'h8;
  localparam int                ST_FP_LSB    = 0;
  localparam int                ST_FL_LSB    = 8;
  localparam int                ST_DEPTH_LSB = 16;
  localparam int                ST_BUSY_BIT  = 24;

  typedef enum logic [2:0] {
    OP_CALL    = 3'h0,
    OP_TRAP    = 3'h1,
    OP_SOFT    = 3'h2,
    OP_EXC     = 3'h3,
    OP_FRAME   = 3'h4,
    OP_RELEASE = 3'h5
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_PULL = 3'b100
  } mgr_state_t;
endpackage : stack_frame_pkg

/* File: sim/mem_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_reg;
  logic [1:0]  pace_reg;
  // Varying wait mixes prompt and slow answers
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      wait_reg <= 2'h0;
      pace_reg <= 2'h0;
    end else begin
      o_ack <= 1'b0;
      // Stale data inverted so no access can rely on it
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
        if (wait_reg == 2'h0) begin
          o_ack <= 1'b1;
          pace_reg <= pace_reg + 2'h1;
          wait_reg <= pace_reg;
          if (i_we) begin
            mem[i_addr] = i_wdata;
          end else begin
            o_rdata <= mem[i_addr];
          end
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
    end
  end
endmodule : mem_partner
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n, op_v, rdy, wen, ferr, mreq, mwe, mack, rwr, rrd, rdv, rd_p, rg_p;
  logic [2:0]  op_k;
  logic [3:0]  op_a, op_b, pfl, rcode, wcode, fsz, raddr;
  logic [5:0]  pfp, fbp;
  logic [31:0] rpc, rsr, rdata, wdata, maddr, mwd, mrd, rwd, rrdat, seed;
  logic [31:0] w [16];
  logic [31:0] q_reg[$], q_rd[$];
  logic [64:0] q_mem[$];
  logic [64:0] m;
  int          err_total = 0, compares = 0, ferr_n = 0, cyc = 0;

  always #2 clk = ~clk;

  register_stack_frame_manager i_dut (
    .i_core_clk(clk), .i_resetn(rst_n), .i_op_valid(op_v), .i_op_kind(op_k),
    .i_op_a(op_a), .i_op_b(op_b), .i_prev_fp(pfp), .i_prev_fl(pfl), .i_ret_pc(rpc),
    .i_ret_sr(rsr), .o_op_ready(rdy), .i_rd_code(rcode), .o_rd_data(rdata),
    .i_wr_en(wen), .i_wr_code(wcode), .i_wr_data(wdata), .o_frame_base_pointer(fbp),
    .o_frame_size_field(fsz), .o_frame_error(ferr), .o_mem_req(mreq), .o_mem_we(mwe),
    .o_mem_addr(maddr), .o_mem_wdata(mwd), .i_mem_ack(mack), .i_mem_rdata(mrd),
    .i_reg_addr(raddr), .i_reg_wdata(rwd), .i_reg_wr(rwr), .i_reg_rd(rrd),
    .o_reg_rdata(rrdat));

  mem_partner i_mem (
    .i_core_clk(clk), .i_resetn(rst_n), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mwd), .o_ack(mack), .o_rdata(mrd));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Results land one cycle after the strobe cycle
  always @(posedge clk) begin
    if (rg_p) check("reg_rdata", rrdat, q_reg.pop_front());
    if (rd_p) check("rd_data", rdata, q_rd.pop_front());
    if (mreq && mack) begin
      m = q_mem.pop_front();
      check("mem_we", {31'h0, mwe}, {31'h0, m[64]});
      check("mem_addr", maddr, m[63:32]);
      if (m[64]) check("mem_wdata", mwd, m[31:0]);
    end
    if (ferr) ferr_n++;
    rg_p <= rrd;
    rd_p <= rdv;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    raddr <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    raddr <= a;
    rrd <= 1'b1;
    q_reg.push_back(e);
    @(posedge clk);
    rrd <= 1'b0;
  endtask : reg_rd

  task automatic core_rd(input logic [3:0] c, input logic [31:0] e);
    @(posedge clk);
    rcode <= c;
    rdv <= 1'b1;
    q_rd.push_back(e);
    @(posedge clk);
    rdv <= 1'b0;
  endtask : core_rd

  task automatic op(input logic [2:0] k, input logic [3:0] a, input logic [3:0] b,
                    input logic [5:0] pf, input logic [3:0] pl, input logic [5:0] eb,
                    input logic [3:0] es);
    int n;
    @(posedge clk);
    op_v <= 1'b1;
    op_k <= k;
    op_a <= a;
    op_b <= b;
    pfp <= pf;
    pfl <= pl;
    @(posedge clk);
    op_v <= 1'b0;
    n = 0;
    #1;
    while (rdy !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready", {31'h0, rdy}, 32'h1);
    check("base", {26'h0, fbp}, {26'h0, eb});
    check("size", {28'h0, fsz}, {28'h0, es});
  endtask : op

  initial begin
    {rst_n, op_v, wen, rwr, rrd, rdv, rd_p, rg_p} = '0;
    {op_k, op_a, op_b, pfl, rcode, wcode, raddr, pfp} = '0;
    {wdata, rwd} = '0;
    seed = 32'h65A7;
    rpc = lfsr(seed);
    rsr = lfsr(rpc);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("base_rst", {26'h0, fbp}, 32'h0);
    reg_rd(4'h8, 32'h0006_0600);
    reg_rd(4'h4, 32'hFFFF_FFFF);
    reg_rd(4'hC, 32'h0);
    reg_wr(4'h8, 32'hFFFF_FFFF);
    reg_rd(4'h8, 32'h0006_0600);
    reg_wr(4'h0, 32'h0000_0100);
    // Limit below the top so the next push must end in a frame error
    reg_wr(4'h4, 32'h0000_00FC);
    seed = rsr;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      w[i] = seed;
      @(posedge clk);
      wen <= 1'b1;
      wcode <= i[3:0];
      wdata <= seed;
    end
    @(posedge clk);
    wen <= 1'b0;
    core_rd(4'h5, w[5]);
    op(stack_frame_pkg::OP_CALL, 4'h9, 4'h0, 6'h0, 4'h0, 6'h09, 4'h6);
    core_rd(4'h0, rpc);
    core_rd(4'h1, rsr);
    op(stack_frame_pkg::OP_EXC, 4'h0, 4'h0, 6'h0, 4'h0, 6'h0F, 4'h2);
    op(stack_frame_pkg::OP_FRAME, 4'h0, 4'h2, 6'h0, 4'h0, 6'h0D, 4'h0);
    core_rd(4'h2, rpc);
    op(stack_frame_pkg::OP_CALL, 4'h0, 4'h0, 6'h0, 4'h0, 6'h1D, 4'h6);
    op(stack_frame_pkg::OP_TRAP, 4'h3, 4'h0, 6'h0, 4'h0, 6'h20, 4'h6);
    op(stack_frame_pkg::OP_SOFT, 4'h5, 4'h0, 6'h0, 4'h0, 6'h25, 4'h6);
    op(stack_frame_pkg::OP_FRAME, 4'h0, 4'h0, 6'h0, 4'h0, 6'h25, 4'h0);
    op(stack_frame_pkg::OP_CALL, 4'h0, 4'h0, 6'h0, 4'h0, 6'h35, 4'h6);
    // Oldest fifteen registers spill ascending from the top
    for (int i = 0; i < 15; i++) begin
      q_mem.push_back({1'b1, 32'h100 + 32'(4 * i), (i == 9) ? rpc : (i == 10) ? rsr : w[i]});
    end
    op(stack_frame_pkg::OP_FRAME, 4'h0, 4'h0, 6'h0, 4'h0, 6'h35, 4'h0);
    reg_rd(4'h0, 32'h0000_013C);
    check("frame_error_count", 32'(ferr_n), 32'h1);
    op(stack_frame_pkg::OP_RELEASE, 4'h0, 4'h0, 6'h25, 4'h0, 6'h25, 4'h0);
    op(stack_frame_pkg::OP_RELEASE, 4'h0, 4'h0, 6'h20, 4'h6, 6'h20, 4'h6);
    op(stack_frame_pkg::OP_RELEASE, 4'h0, 4'h0, 6'h1D, 4'h6, 6'h1D, 4'h6);
    q_mem.push_back({1'b0, 32'h138, 32'h0});
    q_mem.push_back({1'b0, 32'h134, 32'h0});
    op(stack_frame_pkg::OP_RELEASE, 4'h0, 4'h0, 6'h0D, 4'h0, 6'h0D, 4'h0);
    core_rd(4'h0, w[13]);
    core_rd(4'h1, w[14]);
    core_rd(4'h3, rsr);
    reg_rd(4'h0, 32'h0000_0134);
    reg_rd(4'h8, 32'h0010_000D);
    repeat (3) @(posedge clk);
    check("mem_queue_left", 32'(q_mem.size()), 32'h0);
    check("frame_error_final", 32'(ferr_n), 32'h1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
